// ===== hdl/chc_pkg.sv
// shared constants and types for the charger control register bank
package chc_pkg;

  // register offsets
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_CONTROL = 8'h01;
  localparam logic [7:0] REG_BATTERY = 8'h02;
  localparam logic [7:0] REG_IDENT   = 8'h03;

  // status field positions
  localparam int unsigned STAT_KICK_BIT   = 7;
  localparam int unsigned STAT_ENABLE_BIT = 6;

  // control field positions
  localparam int unsigned CTRL_LIMIT_MSB = 7;
  localparam int unsigned CTRL_LIMIT_LSB = 6;
  localparam int unsigned CTRL_WEAK_MSB  = 5;
  localparam int unsigned CTRL_WEAK_LSB  = 4;
  localparam int unsigned CTRL_TERM_BIT  = 3;
  localparam int unsigned CTRL_DIS_BIT   = 2;
  localparam int unsigned CTRL_HIZ_BIT   = 1;
  localparam int unsigned CTRL_MODE_BIT  = 0;

  // battery voltage field positions
  localparam int unsigned BATT_VREG_MSB = 7;
  localparam int unsigned BATT_VREG_LSB = 2;
  localparam int unsigned BATT_POL_BIT  = 1;
  localparam int unsigned BATT_EN_BIT   = 0;

  // reset values
  localparam logic [7:0] CONTROL_RESET     = 8'h30;
  localparam logic [7:0] BATTERY_RESET     = 8'h0a;
  localparam logic       STAT_ENABLE_RESET = 1'h1;

  // identification codes, values arbitrary
  localparam logic [2:0] MAKER_CODE    = 3'h5;
  localparam logic [1:0] PART_CODE     = 2'h2;
  localparam logic [2:0] REVISION_CODE = 3'h1;

  // serial target address, value arbitrary
  localparam logic [6:0] DEVICE_ADDR = 7'h5a;

  // serial slot length: eight data bits then acknowledge
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  typedef enum logic [2:0] {
    PH_ADDR    = 3'b000,
    PH_POINTER = 3'b001,
    PH_WRITE   = 3'b010,
    PH_READ    = 3'b011,
    PH_IGNORE  = 3'b100
  } chc_phase_t;

  typedef enum logic [1:0] {
    CS_READY    = 2'b00,
    CS_CHARGING = 2'b01,
    CS_DONE     = 2'b10,
    CS_FAULT    = 2'b11
  } chc_charge_state_t;

  typedef enum logic [2:0] {
    CF_NORMAL    = 3'b000,
    CF_INPUT_OV  = 3'b001,
    CF_SLEEP     = 3'b010,
    CF_POOR_SRC  = 3'b011,
    CF_OUTPUT_OV = 3'b100,
    CF_THERMAL   = 3'b101,
    CF_TIMER     = 3'b110,
    CF_NO_BATT   = 3'b111
  } chc_charge_fault_t;

  typedef enum logic [2:0] {
    BF_NORMAL   = 3'b000,
    BF_BUS_OV   = 3'b001,
    BF_OVERLOAD = 3'b010,
    BF_BATT_LOW = 3'b011,
    BF_BATT_OV  = 3'b100,
    BF_THERMAL  = 3'b101,
    BF_TIMER    = 3'b110,
    BF_UNUSED   = 3'b111
  } chc_boost_fault_t;

endpackage

// ===== hdl/chc_link.sv
// serial link engine on the link clock: address, pointer, write and read bytes
module chc_link (
  input  wire logic       sclClk,
  input  wire logic       reset_n,
  input  wire logic       frameRst,
  input  wire logic       sdaIn,
  input  wire logic [7:0] holdData,
  output logic      [7:0] wrAddr,
  output logic      [7:0] wrData,
  output logic            wrToggle,
  output logic      [7:0] rdAddr,
  output logic            rdToggle,
  output logic            sdaOut,
  output logic            sdaOe
);

  typedef struct packed {
    logic [3:0]         bitCnt;
    chc_pkg::chc_phase_t phase;
    logic [7:0]         shiftIn;
    logic [7:0]         txShift;
    logic               ackDrive;
    logic               readFirst;
  } chc_engine_t;

  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
    logic       wrToggle;
    logic [7:0] rdAddr;
    logic       rdToggle;
  } chc_mailbox_t;

  chc_engine_t  eng;
  chc_engine_t  next_eng;
  chc_mailbox_t box;
  chc_mailbox_t next_box;
  logic [7:0]   byteNow;

  assign wrAddr   = box.wrAddr;
  assign wrData   = box.wrData;
  assign wrToggle = box.wrToggle;
  assign rdAddr   = box.rdAddr;
  assign rdToggle = box.rdToggle;
  assign byteNow  = {eng.shiftIn[6:0], sdaIn};

  ////////////////////////////////////////////////////////////////////////////////
  // byte sequencing
  always_comb begin
    next_eng = eng;
    next_box = box;
    if (eng.bitCnt == chc_pkg::ACK_SLOT) begin
      next_eng.bitCnt   = 4'h0;
      next_eng.ackDrive = 1'b0;
      if (eng.phase == chc_pkg::PH_READ) begin
        if (eng.readFirst || !sdaIn) begin
          // load byte, prefetch the next one
          next_eng.txShift   = holdData;
          next_eng.readFirst = 1'b0;
          next_box.ptr       = box.ptr + 8'h01;
          next_box.rdAddr    = box.ptr + 8'h01;
          next_box.rdToggle  = ~box.rdToggle;
        end else begin
          next_eng.phase = chc_pkg::PH_IGNORE;
        end
      end
    end else begin
      next_eng.shiftIn = byteNow;
      next_eng.bitCnt  = eng.bitCnt + 4'h1;
      if (eng.phase == chc_pkg::PH_READ) begin
        next_eng.txShift = {eng.txShift[6:0], 1'b0};
      end
      if (eng.bitCnt == chc_pkg::LAST_BIT) begin
        case (eng.phase)
          chc_pkg::PH_ADDR: begin
            if (byteNow[7:1] == chc_pkg::DEVICE_ADDR) begin
              next_eng.ackDrive = 1'b1;
              if (byteNow[0]) begin
                next_eng.phase     = chc_pkg::PH_READ;
                next_eng.readFirst = 1'b1;
                next_box.rdAddr    = box.ptr;
                next_box.rdToggle  = ~box.rdToggle;
              end else begin
                next_eng.phase = chc_pkg::PH_POINTER;
              end
            end else begin
              next_eng.phase = chc_pkg::PH_IGNORE;
            end
          end
          chc_pkg::PH_POINTER: begin
            next_eng.ackDrive = 1'b1;
            next_box.ptr      = byteNow;
            next_eng.phase    = chc_pkg::PH_WRITE;
          end
          chc_pkg::PH_WRITE: begin
            next_eng.ackDrive = 1'b1;
            next_box.wrAddr   = box.ptr;
            next_box.wrData   = byteNow;
            next_box.wrToggle = ~box.wrToggle;
            next_box.ptr      = box.ptr + 8'h01;
          end
          default: begin
            next_eng.ackDrive = 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // engine restarts on every start, mailbox only on reset
  always_ff @(posedge sclClk or posedge frameRst) begin
    if (frameRst) begin
      eng <= '0;
    end else begin
      eng <= next_eng;
    end
  end

  always_ff @(posedge sclClk or negedge reset_n) begin
    if (!reset_n) begin
      box <= '0;
    end else begin
      box <= next_box;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // data line changes only while the link clock is low
  always_ff @(negedge sclClk or posedge frameRst) begin
    if (frameRst) begin
      sdaOe  <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
      sdaOe  <= (eng.bitCnt == chc_pkg::ACK_SLOT && eng.ackDrive) ||
                (eng.phase == chc_pkg::PH_READ && eng.bitCnt != chc_pkg::ACK_SLOT && !eng.txShift[7]);
    end
  end

endmodule

// ===== hdl/chc_register_bank.sv
// charger control register bank: core registers, link crossing, status readback
module chc_register_bank (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       sclClk,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic       hostModePin,
  input  wire logic       chargeStateHi,
  input  wire logic       chargeStateLo,
  input  wire logic       boostActive,
  input  wire logic [2:0] faultCode,
  output logic            safetyTimerKick,
  output logic            statPinEnable,
  output logic      [1:0] inputLimitSel,
  output logic            weakBatterySelHi,
  output logic            weakBatterySelLo,
  output logic            terminationEnable,
  output logic            chargerDisable,
  output logic            highImpedanceSelect,
  output logic            operatingModeSelect,
  output logic      [5:0] regulationVoltageField,
  output logic            hostPinPolarity,
  output logic            hostPinEnable,
  output logic            hostModeRequest
);

  typedef struct packed {
    logic       sclMeta;
    logic       sclSync;
    logic       sdaMeta;
    logic       sdaSync;
    logic       sdaPrev;
    logic       pinMeta;
    logic       pinSync;
    logic [5:0] liveMeta;
    logic [5:0] liveSync;
    logic       wrMeta;
    logic       wrSync;
    logic       wrSeen;
    logic       rdMeta;
    logic       rdSync;
    logic       rdSeen;
    logic       frameRst;
    logic       timerKick;
    logic       statEnable;
    logic [7:0] control;
    logic [7:0] battery;
    logic [7:0] holding;
    logic       hostReq;
  } chc_core_t;

  chc_core_t  st;
  chc_core_t  next_st;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  logic       wrToggle;
  logic [7:0] rdAddr;
  logic       rdToggle;

  ////////////////////////////////////////////////////////////////////////////////
  // register readback
  function automatic logic [7:0] readReg(input logic [7:0] addr, input chc_core_t s);
    logic [2:0] shownFault;
    shownFault = s.liveSync[2:0];
    if (s.liveSync[3] && shownFault == chc_pkg::BF_UNUSED) begin
      shownFault = chc_pkg::BF_NORMAL;
    end
    case (addr)
      chc_pkg::REG_STATUS:  readReg = {s.pinSync, s.statEnable, s.liveSync[5:3], shownFault};
      chc_pkg::REG_CONTROL: readReg = s.control;
      chc_pkg::REG_BATTERY: readReg = s.battery;
      chc_pkg::REG_IDENT:   readReg = {chc_pkg::MAKER_CODE, chc_pkg::PART_CODE, chc_pkg::REVISION_CODE};
      default:              readReg = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // link engine
  chc_link u_link (
    .sclClk   (sclClk),
    .reset_n  (reset_n),
    .frameRst (st.frameRst),
    .sdaIn    (sdaIn),
    .holdData (st.holding),
    .wrAddr   (wrAddr),
    .wrData   (wrData),
    .wrToggle (wrToggle),
    .rdAddr   (rdAddr),
    .rdToggle (rdToggle),
    .sdaOut   (sdaOut),
    .sdaOe    (sdaOe)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // core next state
  always_comb begin
    next_st = st;
    // two-stage synchronisers
    next_st.sclMeta  = sclClk;
    next_st.sclSync  = st.sclMeta;
    next_st.sdaMeta  = sdaIn;
    next_st.sdaSync  = st.sdaMeta;
    next_st.sdaPrev  = st.sdaSync;
    next_st.pinMeta  = hostModePin;
    next_st.pinSync  = st.pinMeta;
    next_st.liveMeta = {chargeStateHi, chargeStateLo, boostActive, faultCode};
    next_st.liveSync = st.liveMeta;
    next_st.wrMeta   = wrToggle;
    next_st.wrSync   = st.wrMeta;
    next_st.wrSeen   = st.wrSync;
    next_st.rdMeta   = rdToggle;
    next_st.rdSync   = st.rdMeta;
    next_st.rdSeen   = st.rdSync;

    // start holds engine in reset briefly, stop holds it until next start
    next_st.frameRst = 1'b0;
    if (st.sclSync && st.sdaPrev && !st.sdaSync) begin
      next_st.frameRst = 1'b1;
    end else if (st.sclSync && !st.sdaPrev && st.sdaSync) begin
      next_st.frameRst = 1'b1;
    end else if (st.frameRst && !st.sclSync) begin
      next_st.frameRst = 1'b0;
    end else if (st.frameRst && !(st.sdaPrev == 1'b0 && st.sdaSync == 1'b0)) begin
      next_st.frameRst = 1'b1;
    end

    // kick is a single-cycle pulse, cleared without host action
    next_st.timerKick = 1'b0;

    // host writes land on toggle edges
    if (st.wrSync != st.wrSeen) begin
      case (wrAddr)
        chc_pkg::REG_STATUS: begin
          next_st.statEnable = wrData[chc_pkg::STAT_ENABLE_BIT];
          next_st.timerKick  = wrData[chc_pkg::STAT_KICK_BIT];
        end
        chc_pkg::REG_CONTROL: next_st.control = wrData;
        chc_pkg::REG_BATTERY: next_st.battery = wrData;
        default:              next_st.holding = st.holding;
      endcase
    end

    // read requests capture a byte for the link
    if (st.rdSync != st.rdSeen) begin
      next_st.holding = readReg(rdAddr, st);
    end

    // host pin request honours enable and active level
    next_st.hostReq = st.battery[chc_pkg::BATT_EN_BIT] &&
                      (st.pinSync == st.battery[chc_pkg::BATT_POL_BIT]);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // core registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st            <= '0;
      st.frameRst   <= 1'b1;
      // idle bus levels, no false stop after reset
      st.sclMeta    <= 1'b1;
      st.sclSync    <= 1'b1;
      st.sdaMeta    <= 1'b1;
      st.sdaSync    <= 1'b1;
      st.sdaPrev    <= 1'b1;
      st.statEnable <= chc_pkg::STAT_ENABLE_RESET;
      st.control    <= chc_pkg::CONTROL_RESET;
      st.battery    <= chc_pkg::BATTERY_RESET;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control outputs
  assign safetyTimerKick        = st.timerKick;
  assign statPinEnable          = st.statEnable;
  assign inputLimitSel          = st.control[chc_pkg::CTRL_LIMIT_MSB:chc_pkg::CTRL_LIMIT_LSB];
  assign weakBatterySelHi       = st.control[chc_pkg::CTRL_WEAK_MSB];
  assign weakBatterySelLo       = st.control[chc_pkg::CTRL_WEAK_LSB];
  assign terminationEnable      = st.control[chc_pkg::CTRL_TERM_BIT];
  assign chargerDisable         = st.control[chc_pkg::CTRL_DIS_BIT];
  assign highImpedanceSelect    = st.control[chc_pkg::CTRL_HIZ_BIT];
  assign operatingModeSelect    = st.control[chc_pkg::CTRL_MODE_BIT];
  assign regulationVoltageField = st.battery[chc_pkg::BATT_VREG_MSB:chc_pkg::BATT_VREG_LSB];
  assign hostPinPolarity        = st.battery[chc_pkg::BATT_POL_BIT];
  assign hostPinEnable          = st.battery[chc_pkg::BATT_EN_BIT];
  assign hostModeRequest        = st.hostReq;

endmodule

// ===== tb/chc_bank_assertions.sv
// port checker for the charger control register bank
module chc_bank_checker (
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic       sclClk,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       hostModePin,
  input wire logic       safetyTimerKick,
  input wire logic       statPinEnable,
  input wire logic [1:0] inputLimitSel,
  input wire logic       weakBatterySelHi,
  input wire logic       weakBatterySelLo,
  input wire logic       terminationEnable,
  input wire logic       chargerDisable,
  input wire logic       highImpedanceSelect,
  input wire logic       operatingModeSelect,
  input wire logic [5:0] regulationVoltageField,
  input wire logic       hostPinPolarity,
  input wire logic       hostPinEnable,
  input wire logic       hostModeRequest
);
  localparam int IDLE_MIN = 20;
  logic [7:0] idleCnt;
  logic [7:0] next_idleCnt;
  logic [7:0] ctrlVal;
  logic [7:0] battVal;
  assign ctrlVal = {inputLimitSel, weakBatterySelHi, weakBatterySelLo, terminationEnable, chargerDisable,
                    highImpedanceSelect, operatingModeSelect};
  assign battVal = {regulationVoltageField, hostPinPolarity, hostPinEnable};
  ////////////////////////////////////////////////////////////////////////////////
  // cycles of link clock held high
  always_comb begin
    next_idleCnt = idleCnt;
    if (!sclClk) begin
      next_idleCnt = 8'h00;
    end else if (idleCnt != 8'hff) begin
      next_idleCnt = idleCnt + 8'h01;
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      idleCnt <= 8'h00;
    end else begin
      idleCnt <= next_idleCnt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_kick_one_cycle: assert property (safetyTimerKick |=> !safetyTimerKick)
    else $error("timer kick longer than one cycle");
  a_kick_in_frame: assert property (safetyTimerKick |-> idleCnt < IDLE_MIN)
    else $error("timer kick outside a frame");
  a_reset_values: assert property ($rose(reset_n) |-> ctrlVal == 8'h30 && battVal == 8'h0a && statPinEnable)
    else $error("outputs not at reset values");
  a_idle_stable: assert property (idleCnt >= IDLE_MIN |-> $stable(ctrlVal) && $stable(battVal))
    else $error("control outputs moved while link idle");
  a_req_disabled: assert property (!hostPinEnable [*2] |-> !hostModeRequest)
    else $error("host mode request while pin disabled");
  a_req_follows: assert property (($stable(hostModePin) && hostPinEnable && $stable(hostPinPolarity)) [*8]
    |-> hostModeRequest == (hostModePin == hostPinPolarity))
    else $error("host mode request does not follow pin");
  a_open_drain: assert property (sdaOut == 1'b0)
    else $error("data line driven high");
  a_oe_idle: assert property (idleCnt >= IDLE_MIN |-> !sdaOe)
    else $error("data line pulled while link idle");
endmodule
bind chc_register_bank chc_bank_checker i_chc_bank_checker (.core_clk, .reset_n, .sclClk, .sdaOut, .sdaOe,
  .hostModePin, .safetyTimerKick, .statPinEnable, .inputLimitSel, .weakBatterySelHi, .weakBatterySelLo,
  .terminationEnable, .chargerDisable, .highImpedanceSelect, .operatingModeSelect, .regulationVoltageField,
  .hostPinPolarity, .hostPinEnable, .hostModeRequest);

// ===== tb/chc_host_model.sv
// serial controller model: drives link clock and pulls data line low
module chc_host_model #(
  parameter int HALF = 1200
) (
  output logic     sclClk,
  output logic     hostLow,
  input wire logic sdaLine
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclClk = 1'b1;
    hostLow = 1'b0;
  end
  task automatic start();
    hostLow = 1'b0;
    #(HALF) sclClk = 1'b1;
    #(HALF) hostLow = 1'b1;
    #(HALF) sclClk = 1'b0;
  endtask
  task automatic stop();
    hostLow = 1'b1;
    #(HALF) sclClk = 1'b1;
    #(HALF) hostLow = 1'b0;
    #(HALF);
  endtask
  task automatic putByte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      hostLow = ~d[i];
      #(HALF) sclClk = 1'b1;
      #(HALF) sclClk = 1'b0;
    end
    hostLow = 1'b0;
    #(HALF) sclClk = 1'b1;
    ack = ~sdaLine;
    #(HALF) sclClk = 1'b0;
  endtask
  task automatic getByte(input logic nack, output logic [7:0] d);
    hostLow = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #(HALF) sclClk = 1'b1;
      d[i] = sdaLine;
      #(HALF) sclClk = 1'b0;
    end
    hostLow = ~nack;
    #(HALF) sclClk = 1'b1;
    #(HALF) sclClk = 1'b0;
  endtask
endmodule

// ===== tb/charger_control_register_bank_test.sv
// self-checking bench for the charger control register bank
module charger_control_register_bank_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk = 1'b0, reset_n = 1'b0, hostModePin = 1'b0, chargeStateHi = 1'b0, chargeStateLo = 1'b0;
  logic       boostActive = 1'b0, sdaIn, sdaOut, sdaOe, sclClk, hostLow, safetyTimerKick, statPinEnable;
  logic [2:0] faultCode = 3'h0;
  logic [1:0] inputLimitSel;
  logic       weakBatterySelHi, weakBatterySelLo, terminationEnable, chargerDisable, highImpedanceSelect;
  logic       operatingModeSelect, hostPinPolarity, hostPinEnable, hostModeRequest, ack;
  logic [5:0] regulationVoltageField;
  logic [7:0] d, v, w, exp;
  int         error_cnt = 0, checks_done = 0, kickCnt = 0;
  assign sdaIn = !(hostLow || (sdaOe && !sdaOut));
  chc_register_bank i_chc_register_bank (.core_clk, .reset_n, .sclClk, .sdaIn, .sdaOut, .sdaOe, .hostModePin,
    .chargeStateHi, .chargeStateLo, .boostActive, .faultCode, .safetyTimerKick, .statPinEnable, .inputLimitSel,
    .weakBatterySelHi, .weakBatterySelLo, .terminationEnable, .chargerDisable, .highImpedanceSelect,
    .operatingModeSelect, .regulationVoltageField, .hostPinPolarity, .hostPinEnable, .hostModeRequest);
  chc_host_model #(.HALF(1200)) i_chc_host_model (.sclClk, .hostLow, .sdaLine(sdaIn));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (safetyTimerKick === 1'b1) kickCnt++;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check8(input string what, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic sendAcked(input logic [7:0] b);
    i_chc_host_model.putByte(b, ack);
    check8("byte ack", 8'h01, {7'h00, ack});
  endtask
  task automatic regWrite(input logic [7:0] a, input logic [7:0] x);
    i_chc_host_model.start();
    sendAcked({chc_pkg::DEVICE_ADDR, 1'b0});
    sendAcked(a);
    sendAcked(x);
    i_chc_host_model.stop();
  endtask
  task automatic regRead(input logic [7:0] a, output logic [7:0] x);
    i_chc_host_model.start();
    sendAcked({chc_pkg::DEVICE_ADDR, 1'b0});
    sendAcked(a);
    i_chc_host_model.start();
    sendAcked({chc_pkg::DEVICE_ADDR, 1'b1});
    i_chc_host_model.getByte(1'b1, x);
    i_chc_host_model.stop();
  endtask
  task automatic chkOut(input logic [7:0] c, input logic [7:0] b);
    check8("control pins", c, {inputLimitSel, weakBatterySelHi, weakBatterySelLo, terminationEnable,
           chargerDisable, highImpedanceSelect, operatingModeSelect});
    check8("battery pins", b, {regulationVoltageField, hostPinPolarity, hostPinEnable});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #10_000_000;
    error_cnt++;
    results();
  end
  initial begin
    repeat (20) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge core_clk);
    chkOut(chc_pkg::CONTROL_RESET, chc_pkg::BATTERY_RESET);
    check8("stat enable", 8'h01, {7'h00, statPinEnable});
    regRead(chc_pkg::REG_CONTROL, d);
    check8("control", chc_pkg::CONTROL_RESET, d);
    regRead(chc_pkg::REG_BATTERY, d);
    check8("battery", chc_pkg::BATTERY_RESET, d);
    regRead(chc_pkg::REG_IDENT, d);
    check8("ident", {chc_pkg::MAKER_CODE, chc_pkg::PART_CODE, chc_pkg::REVISION_CODE}, d);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = {i[1:0], ~i[1:0], i[0], ~i[0], i[1], ~i[1]};
      w = {~i[1:0], i[1:0], i[0], ~i[1], i[1], i[0]};
      i_chc_host_model.start();
      sendAcked({chc_pkg::DEVICE_ADDR, 1'b0});
      sendAcked(chc_pkg::REG_CONTROL);
      sendAcked(v);
      sendAcked(w);
      i_chc_host_model.stop();
      chkOut(v, w);
      regRead(chc_pkg::REG_CONTROL, d);
      check8("control", v, d);
      regRead(chc_pkg::REG_BATTERY, d);
      check8("battery", w, d);
    end
    i_chc_host_model.start();
    sendAcked({chc_pkg::DEVICE_ADDR, 1'b0});
    sendAcked(chc_pkg::REG_CONTROL);
    i_chc_host_model.start();
    sendAcked({chc_pkg::DEVICE_ADDR, 1'b1});
    i_chc_host_model.getByte(1'b0, d);
    check8("burst control", v, d);
    i_chc_host_model.getByte(1'b1, d);
    check8("burst battery", w, d);
    i_chc_host_model.stop();
    $display("test fields done");
    regWrite(chc_pkg::REG_IDENT, 8'h00);
    regRead(chc_pkg::REG_IDENT, d);
    check8("ident", {chc_pkg::MAKER_CODE, chc_pkg::PART_CODE, chc_pkg::REVISION_CODE}, d);
    regWrite(8'h05, 8'hff);
    regRead(8'h05, d);
    check8("unmapped", 8'h00, d);
    chkOut(v, w);
    i_chc_host_model.start();
    i_chc_host_model.putByte({chc_pkg::DEVICE_ADDR ^ 7'h01, 1'b0}, ack);
    check8("foreign ack", 8'h00, {7'h00, ack});
    i_chc_host_model.putByte(8'h01, ack);
    i_chc_host_model.putByte(8'h00, ack);
    i_chc_host_model.stop();
    chkOut(v, w);
    $display("test refusals done");
    for (int i = 0; i < 16; i++) begin
      @(negedge core_clk);
      {boostActive, chargeStateHi, chargeStateLo, hostModePin} = i[3:0];
      faultCode = i[2:0];
      repeat (10) @(negedge core_clk);
      exp = {i[0], 1'b1, i[2:1], i[3], (i[3] && i[2:0] == 3'h7) ? 3'h0 : i[2:0]};
      regRead(chc_pkg::REG_STATUS, d);
      check8("status", exp, d);
    end
    $display("test status done");
    @(negedge core_clk);
    {boostActive, chargeStateHi, chargeStateLo, hostModePin, faultCode} = 7'h00;
    kickCnt = 0;
    regWrite(chc_pkg::REG_STATUS, 8'h80);
    check8("kicks", 8'h01, 8'(kickCnt));
    check8("stat enable", 8'h00, {7'h00, statPinEnable});
    regRead(chc_pkg::REG_STATUS, d);
    check8("status", 8'h00, d);
    regWrite(chc_pkg::REG_STATUS, 8'h40);
    check8("kicks", 8'h01, 8'(kickCnt));
    check8("stat enable", 8'h01, {7'h00, statPinEnable});
    $display("test kick done");
    regWrite(chc_pkg::REG_BATTERY, 8'h0b);
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk);
      hostModePin = i[0];
      if (i == 2) begin
        regWrite(chc_pkg::REG_BATTERY, 8'h09);
      end
      repeat (10) @(negedge core_clk);
      check8("host request", {7'h00, i[0] == (i < 2)}, {7'h00, hostModeRequest});
    end
    $display("test host pin done");
    results();
  end
endmodule
